/* File: timer_unit.sv */
// Timer unit: normal and split counting, event generators, event input and interrupt flags.
`timescale 1ns/1ps
`default_nettype none
`include "timer_unit_regs.svh"
module timer_unit import timer_unit_pkg::*; (
   input wire logic mclk,
   input wire logic nrst,
   input wire ctrl_t ctrl,
   input wire logic hardResetCmd,
   input wire logic [15:0] period,
   input wire logic [15:0] compareValue [3],
   input wire event_cfg_t eventCfg,
   input wire logic eventIn,
   input wire logic [`IRQ_WIDTH-1:0] irqEnable,
   input wire logic flagClearWrite,
   input wire logic [`IRQ_WIDTH-1:0] flagClearData,
   output logic [15:0] countValue,
   output logic [`IRQ_WIDTH-1:0] irqFlags,
   output logic irqRequest,
   output events_t eventsOut
);

   logic tick;
   logic eventPrev_q;
   logic countStep;
   logic countDir;
   logic [15:0] count_d;
   logic [`IRQ_WIDTH-1:0] setVec;
   logic [`IRQ_WIDTH-1:0] flags_d;
   logic hardReset;
   events_t events_d;

   // A hard reset is only honoured while the unit is stopped.
   assign hardReset = hardResetCmd && !ctrl.enable;

   // Prescaler; no sleep input exists, so idle sleep changes nothing here.
   timer_prescaler prescaler (
      .mclk(mclk),
      .nrst(nrst),
      .run(ctrl.enable),
      .prescaleSelect(ctrl.prescaleSelect),
      .tick(tick)
   );

   // Normal-mode step and direction from the prescaler and the event input.
   always_comb begin
      countStep = 1'b0;
      countDir = ctrl.countDown;
      if (ctrl.enable && !ctrl.splitEnable) begin
         if (eventCfg.countOnEventEnable) begin
            case (eventCfg.eventActionSelect)
               EVENT_ACTION_SELECT_POS_EDGE: countStep = eventIn && !eventPrev_q;
               EVENT_ACTION_SELECT_ANY_EDGE: countStep = eventIn != eventPrev_q;
               EVENT_ACTION_SELECT_HIGH_LEVEL: countStep = tick && eventIn;
               EVENT_ACTION_SELECT_DIRECTION: begin
                  countStep = tick;
                  countDir = eventIn;
               end
               default: countStep = 1'b0;
            endcase
         end else begin
            countStep = tick;
         end
      end
   end

   // Next count and the conditions that raise flags and events together.
   always_comb begin
      count_d = countValue;
      setVec = '0;
      events_d = '0;
      if (ctrl.enable && ctrl.splitEnable && tick) begin
         // Both bytes count down only and reload from their period byte.
         if (countValue[7:0] == 8'h00) begin
            count_d[7:0] = period[7:0];
            setVec[`IRQ_OVF_BIT] = 1'b1;
         end else begin
            count_d[7:0] = countValue[7:0] - 8'h01;
         end
         if (countValue[15:8] == 8'h00) begin
            count_d[15:8] = period[15:8];
            setVec[`IRQ_HIGH_UNDERFLOW_BIT] = 1'b1;
         end else begin
            count_d[15:8] = countValue[15:8] - 8'h01;
         end
         for (int n = 0; n < 3; n++) begin
            if (countValue[7:0] == compareValue[n][7:0]) begin
               setVec[`IRQ_COMPARE_ZERO_BIT + n] = 1'b1;
            end
         end
      end else if (countStep) begin
         if (countDir) begin
            if (countValue == 16'h0000) begin
               count_d = period;
               setVec[`IRQ_OVF_BIT] = 1'b1;
            end else begin
               count_d = countValue - 16'h0001;
            end
         end else begin
            if (countValue == period) begin
               count_d = 16'h0000;
               setVec[`IRQ_OVF_BIT] = 1'b1;
            end else begin
               count_d = countValue + 16'h0001;
            end
         end
         for (int n = 0; n < 3; n++) begin
            if (countValue == compareValue[n]) begin
               setVec[`IRQ_COMPARE_ZERO_BIT + n] = 1'b1;
            end
         end
      end
      // Events mirror the flag set conditions bit for bit.
      events_d.overflowLowUnderflow = setVec[`IRQ_OVF_BIT];
      events_d.highUnderflow = setVec[`IRQ_HIGH_UNDERFLOW_BIT];
      events_d.compare = setVec[`IRQ_COMPARE_ZERO_BIT +: 3];
   end

   // Sticky flags: a new set beats a same-cycle write-one clear.
   always_comb begin
      flags_d = irqFlags;
      if (flagClearWrite) begin
         flags_d = flags_d & ~flagClearData;
      end
      flags_d = flags_d | setVec;
   end

   // Counter register; it is the readback path in both modes.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         countValue <= `COUNT_RESET;
      end else if (hardReset) begin
         countValue <= `COUNT_RESET;
      end else begin
         countValue <= count_d;
      end
   end

   // Previous event level for the edge actions; the input is already synchronous.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         eventPrev_q <= 1'b0;
      end else begin
         eventPrev_q <= eventIn;
      end
   end

   // Flags and the request are updated together so the request never lags a flag.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irqFlags <= `FLAGS_RESET;
         irqRequest <= 1'b0;
      end else if (hardReset) begin
         irqFlags <= `FLAGS_RESET;
         irqRequest <= 1'b0;
      end else begin
         irqFlags <= flags_d;
         irqRequest <= |(flags_d & irqEnable);
      end
   end

   // Event outputs, one cycle per condition.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         eventsOut <= '0;
      end else if (hardReset) begin
         eventsOut <= '0;
      end else begin
         eventsOut <= events_d;
      end
   end

   // Each event pulse is accompanied by its flag.
   AST_EVENT_SETS_FLAG: assert property (@(posedge mclk) disable iff (!nrst)
      eventsOut.overflowLowUnderflow |-> irqFlags[`IRQ_OVF_BIT])
      else $error("Overflow event without its flag.");

   AST_CMP_EVENT_FLAG: assert property (@(posedge mclk) disable iff (!nrst)
      eventsOut.compare[0] |-> irqFlags[`IRQ_COMPARE_ZERO_BIT])
      else $error("Compare event without its flag.");

   // The high underflow event only follows a split-mode cycle.
   AST_HIGH_UNDERFLOW_SPLIT_ONLY: assert property (@(posedge mclk) disable iff (!nrst)
      eventsOut.highUnderflow |-> $past(ctrl.splitEnable))
      else $error("High underflow event outside split mode.");

   AST_IRQ_REQUEST: assert property (@(posedge mclk) disable iff (!nrst)
      irqRequest |-> |(irqFlags & $past(irqEnable)))
      else $error("Interrupt request without enabled flag.");

   AST_STOPPED_HOLDS: assert property (@(posedge mclk) disable iff (!nrst)
      (!ctrl.enable && !hardResetCmd) |=> $stable(countValue))
      else $error("Counter moved while disabled.");

   AST_HARD_RESET: assert property (@(posedge mclk) disable iff (!nrst)
      (hardResetCmd && !ctrl.enable) |=> (countValue == 16'h0000 && irqFlags == 7'h00))
      else $error("Hard reset did not clear the unit.");

   AST_FLAG_CLEAR: assert property (@(posedge mclk) disable iff (!nrst)
      (flagClearWrite && flagClearData[`IRQ_HIGH_UNDERFLOW_BIT] && !ctrl.splitEnable)
      |=> !irqFlags[`IRQ_HIGH_UNDERFLOW_BIT])
      else $error("Write-one did not clear the flag.");

   AST_DIR_DOWN: assert property (@(posedge mclk) disable iff (!nrst)
      (ctrl.enable && !ctrl.splitEnable && eventCfg.countOnEventEnable
       && eventCfg.eventActionSelect == EVENT_ACTION_SELECT_DIRECTION && eventIn && tick
       && countValue != 16'h0000 && !hardResetCmd)
      |=> countValue == $past(countValue) - 16'h0001)
      else $error("Direction mode did not count down.");

   AST_DIR_UP: assert property (@(posedge mclk) disable iff (!nrst)
      (ctrl.enable && !ctrl.splitEnable && eventCfg.countOnEventEnable
       && eventCfg.eventActionSelect == EVENT_ACTION_SELECT_DIRECTION && !eventIn && tick
       && countValue != period && !hardResetCmd)
      |=> countValue == $past(countValue) + 16'h0001)
      else $error("Direction mode did not count up.");

   AST_SPLIT_NO_EVENTS: assert property (@(posedge mclk) disable iff (!nrst)
      (ctrl.enable && ctrl.splitEnable && !tick && !hardResetCmd) |=> $stable(countValue))
      else $error("Split counter moved without a prescaler tick.");

endmodule : timer_unit
`default_nettype wire

/* File: timer_unit_regs.svh */
// Vector widths, field positions, reset values and prescaler masks for the timer unit.
`ifndef TIMER_UNIT_REGS_SVH
`define TIMER_UNIT_REGS_SVH

// Width of the interrupt flag and interrupt enable vectors.
`define IRQ_WIDTH 7
// Flag and enable bit positions; bit 0 doubles as low underflow in split mode.
`define IRQ_OVF_BIT 0
`define IRQ_HIGH_UNDERFLOW_BIT 1
`define IRQ_COMPARE_ZERO_BIT 4
// Reset values.
`define COUNT_RESET 16'h0000
`define FLAGS_RESET 7'h00
// Width of the prescaler counter and the divider masks, one per select code.
`define PRESCALE_WIDTH 10
`define DIV_MASK_1 10'h000
`define DIV_MASK_2 10'h001
`define DIV_MASK_4 10'h003
`define DIV_MASK_8 10'h007
`define DIV_MASK_16 10'h00F
`define DIV_MASK_64 10'h03F
`define DIV_MASK_256 10'h0FF
`define DIV_MASK_1024 10'h3FF

`endif

/* File: timer_unit_pkg.sv */
// Types shared by the timer unit and its prescaler.
package timer_unit_pkg;

   // Event input actions.
   typedef enum logic [2:0] {
      EVENT_ACTION_SELECT_POS_EDGE = 3'h0,
      EVENT_ACTION_SELECT_ANY_EDGE = 3'h1,
      EVENT_ACTION_SELECT_HIGH_LEVEL = 3'h2,
      EVENT_ACTION_SELECT_DIRECTION = 3'h3
   } event_action_select_t;

   // Control bits that software programs.
   typedef struct packed {
      logic enable;
      logic [2:0] prescaleSelect;
      logic splitEnable;
      logic countDown;
   } ctrl_t;

   // Event input configuration.
   typedef struct packed {
      logic countOnEventEnable;
      event_action_select_t eventActionSelect;
   } event_cfg_t;

   // Event generator outputs.
   typedef struct packed {
      logic overflowLowUnderflow;
      logic highUnderflow;
      logic [2:0] compare;
   } events_t;

endpackage : timer_unit_pkg

/* File: timer_prescaler.sv */
// Prescaler that turns the peripheral clock into count ticks.
`timescale 1ns/1ps
`default_nettype none
`include "timer_unit_regs.svh"
module timer_prescaler import timer_unit_pkg::*; (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic run,
   input wire logic [2:0] prescaleSelect,
   output logic tick
);

   logic [`PRESCALE_WIDTH-1:0] div_q;

   // Select code to divider mask.
   function automatic logic [`PRESCALE_WIDTH-1:0] divMask(input logic [2:0] sel);
      case (sel)
         3'h0: divMask = `DIV_MASK_1;
         3'h1: divMask = `DIV_MASK_2;
         3'h2: divMask = `DIV_MASK_4;
         3'h3: divMask = `DIV_MASK_8;
         3'h4: divMask = `DIV_MASK_16;
         3'h5: divMask = `DIV_MASK_64;
         3'h6: divMask = `DIV_MASK_256;
         default: divMask = `DIV_MASK_1024;
      endcase
   endfunction : divMask

   // Free counter cleared while stopped, so the first tick always comes a full period late.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         div_q <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         div_q <= '0;
         tick <= 1'b0;
      end else begin
         div_q <= div_q + 1'b1;
         tick <= ((div_q & divMask(prescaleSelect)) == divMask(prescaleSelect));
      end
   end

endmodule : timer_prescaler
`default_nettype wire

/* File: evt_partner.sv */
// Model of the event network beside the timer: counts event pulses and drives the event input.
`timescale 1ns/1ps
`default_nettype none
module evt_partner import timer_unit_pkg::*; (
   input wire logic mclk,
   input wire logic nrst,
   input wire events_t evts,
   output logic eventIn
);
   int nHigh, nCmp0, nLong;
   events_t last;
   initial eventIn = 1'b0;
   // An event user sees each pulse for one clock, so a pulse seen on two edges counts as long.
   always @(posedge mclk) begin
      if (nrst) begin
         nHigh += evts.highUnderflow;
         nCmp0 += evts.compare[0];
         if ((evts & last) !== 5'h00) nLong++;
      end
      last = evts;
   end
   // Two clocks high and two low, so the synchronous detector sees every edge.
   task automatic burst(input int k);
      repeat (k) begin
         @(negedge mclk);
         eventIn = 1'b1;
         repeat (2) @(negedge mclk);
         eventIn = 1'b0;
         @(negedge mclk);
      end
   endtask : burst
   // A level is changed only at a falling edge.
   task automatic lvl(input logic v);
      @(negedge mclk);
      eventIn = v;
   endtask : lvl
endmodule : evt_partner
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the timer unit with its event network model.
`timescale 1ns/1ps
`default_nettype none
module tb import timer_unit_pkg::*;;
   typedef struct {logic [2:0] ps; logic sp; logic dn; int b; int gap;} row_t;
   logic mclk, nrst, hr, fcw, eventIn, irq;
   ctrl_t ctrl;
   event_cfg_t ecfg;
   events_t ev;
   logic [15:0] per, cnt, c0;
   logic [15:0] cmp [3];
   logic [6:0] ien, fcd, flg;
   int n_fail, comparisons, cyc, h0, c00;
   // Each row: prescale code, split, direction, event bit watched, expected gap in clocks.
   row_t rows [10] = '{'{0, 0, 0, 4, 4}, '{1, 0, 1, 4, 8}, '{2, 0, 0, 4, 16}, '{3, 0, 1, 4, 32},
      '{4, 0, 0, 4, 64}, '{5, 0, 1, 4, 256}, '{6, 0, 0, 4, 1024}, '{7, 0, 1, 4, 4096},
      '{0, 1, 1, 4, 4}, '{2, 1, 1, 3, 24}};
   timer_unit dut (.mclk(mclk), .nrst(nrst), .ctrl(ctrl), .hardResetCmd(hr), .period(per),
      .compareValue(cmp), .eventCfg(ecfg), .eventIn(eventIn), .irqEnable(ien),
      .flagClearWrite(fcw), .flagClearData(fcd), .countValue(cnt), .irqFlags(flg),
      .irqRequest(irq), .eventsOut(ev));
   evt_partner p (.mclk(mclk), .nrst(nrst), .evts(ev), .eventIn(eventIn));
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // The mode may only change while stopped and after a hard reset.
   task automatic setup(logic [2:0] ps, logic sp, logic dn, logic [15:0] pr);
      @(negedge mclk);
      ctrl.enable = 1'b0;
      @(negedge mclk);
      hr = 1'b1;
      @(negedge mclk);
      hr = 1'b0;
      ctrl.splitEnable = sp;
      @(negedge mclk);
      per = pr;
      ctrl.prescaleSelect = ps;
      ctrl.countDown = dn;
      @(negedge mclk);
      ctrl.enable = 1'b1;
   endtask : setup
   // A pulse stands one clock, so it is looked at on every falling edge.
   task automatic waitEv(int b);
      cyc = 0;
      do begin
         @(negedge mclk);
         cyc++;
      end while (ev[b] !== 1'b1 && cyc < 9000);
   endtask : waitEv
   task automatic clr(logic [6:0] m);
      fcd = m;
      fcw = 1'b1;
      @(negedge mclk);
      fcw = 1'b0;
      @(negedge mclk);
   endtask : clr
   // The count is sampled after a settling gap; the level reaches the counter at the next rising edge.
   task automatic lvlCase(logic en, logic [2:0] act, logic v, logic [15:0] d);
      ecfg.countOnEventEnable = en;
      ecfg.eventActionSelect = event_action_select_t'(act);
      setup(3'h0, 1'b0, 1'b0, 16'h0FFF);
      p.lvl(1'b0);
      repeat (20) @(negedge mclk);
      p.lvl(v);
      repeat (3) @(negedge mclk);
      c0 = cnt;
      repeat (8) @(negedge mclk);
      chk("level delta", d, cnt - c0);
   endtask : lvlCase
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // The whole run needs about eight thousand clocks; this allows several times that.
   initial begin
      #400_000;
      n_fail++;
      summarize();
   end
   initial begin
      nrst = 1'b0;
      ctrl = '0;
      hr = 1'b0;
      per = 16'h0003;
      cmp = '{16'h0001, 16'h0002, 16'hFF01};
      ecfg = '0;
      ien = 7'h00;
      fcw = 1'b0;
      fcd = 7'h00;
      repeat (12) @(negedge mclk);
      nrst = 1'b1;
      chk("reset count", 16'h0000, cnt);
      foreach (rows[i]) begin
         setup(rows[i].ps, rows[i].sp, rows[i].dn, rows[i].sp ? 16'h0503 : 16'h0003);
         waitEv(rows[i].b);
         h0 = p.nHigh;
         c00 = p.nCmp0;
         if (rows[i].sp && rows[i].b == 3) chk("high byte", 16'h0005, cnt >> 8);
         else if (rows[i].sp) chk("low byte", 16'h0003, cnt & 16'h00FF);
         else chk("wrap count", rows[i].dn ? 16'h0003 : 16'h0000, cnt);
         waitEv(rows[i].b);
         chk("event gap", 16'(rows[i].gap), 16'(cyc));
         if (rows[i].b == 4) chk("compare events", 16'h0001, 16'(p.nCmp0 - c00));
         if (!rows[i].sp) chk("high events", 16'h0000, 16'(p.nHigh - h0));
         chk("flags", rows[i].sp ? 16'h0073 : 16'h0031, {9'h000, flg});
      end
      // Flags stand while disabled; the request follows flag and enable.
      chk("request off", 16'h0000, {15'h0000, irq});
      ien = 7'h02;
      repeat (2) @(negedge mclk);
      chk("request on", 16'h0001, {15'h0000, irq});
      ctrl.enable = 1'b0;
      clr(7'h01);
      chk("flags after clear", 16'h0072, {9'h000, flg});
      chk("request held", 16'h0001, {15'h0000, irq});
      clr(7'h02);
      chk("flags cleared", 16'h0070, {9'h000, flg});
      chk("request dropped", 16'h0000, {15'h0000, irq});
      lvlCase(1'b1, 3'h2, 1'b1, 16'h0008);
      lvlCase(1'b1, 3'h2, 1'b0, 16'h0000);
      lvlCase(1'b1, 3'h3, 1'b0, 16'h0008);
      lvlCase(1'b1, 3'h3, 1'b1, 16'hFFF8);
      lvlCase(1'b1, 3'h4, 1'b1, 16'h0000);
      lvlCase(1'b0, 3'h2, 1'b0, 16'h0008);
      // The rising-edge action counts each rising edge, the any-edge action each edge; split mode must ignore them all.
      ecfg.countOnEventEnable = 1'b1;
      ecfg.eventActionSelect = event_action_select_t'(3'h0);
      setup(3'h7, 1'b1, 1'b1, 16'h0FFF);
      p.burst(5);
      chk("split ignores", 16'h0001, {15'h0000, cnt == 16'h0000 || cnt == 16'h0FFF});
      setup(3'h0, 1'b0, 1'b0, 16'h0FFF);
      p.burst(5);
      repeat (4) @(negedge mclk);
      chk("rising count", 16'h0005, cnt);
      ecfg.eventActionSelect = event_action_select_t'(3'h1);
      setup(3'h0, 1'b0, 1'b0, 16'h0FFF);
      p.burst(5);
      repeat (4) @(negedge mclk);
      chk("any edge count", 16'h000A, cnt);
      chk("long pulses", 16'h0000, 16'(p.nLong));
      nrst = 1'b0;
      #1;
      chk("reset mid run", 16'h0000, cnt);
      repeat (12) @(negedge mclk);
      nrst = 1'b1;
      summarize();
   end
endmodule : tb
`default_nettype wire
